// >>> pkg/clrx_cfg.svh
// constants for the clear-instruction execute block
`ifndef CLRX_CFG_SVH
`define CLRX_CFG_SVH
// wishbone register offsets (byte addresses)
`define CLRX_ADR_CTRL 8'h00
`define CLRX_ADR_INSTR 8'h04
`define CLRX_ADR_STATUS 8'h08
`define CLRX_ADR_ADDR 8'h0C
`define CLRX_ADR_WDT 8'h10
`define CLRX_ADR_MEM 8'h14
// instruction encodings
`define CLRX_OP_CLRWD 16'h0004
`define CLRX_OP_REGCLR_HI 7'h35
// status bit positions
`define CLRX_ST_Z 2
`define CLRX_ST_PWRDN 3
`define CLRX_ST_TMOUT 4
// control bit positions
`define CLRX_CTRL_EXT 0
// indexed offset threshold and access bank split
`define CLRX_IDX_MAX 8'h5F
`define CLRX_ACC_SPLIT 8'h60
`define CLRX_ACC_HIBANK 4'hF
// reset values and watchdog counter wrap value
`define CLRX_STATUS_RST 8'h18
`define CLRX_ZERO8 8'h00
`define CLRX_WDT_MAX 16'hFFFF
`endif

// >>> pkg/clrx_pkg.sv
// types for the clear-instruction execute block
package clrx_pkg;
  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {CLRX_Q1, CLRX_Q2, CLRX_Q3, CLRX_Q4} clrx_phase_type;
  // decoded instruction kind
  typedef enum logic [1:0] {CLRX_NONE, CLRX_FILE_CLR, CLRX_WDOG_CLR} clrx_kind_type;
  // data memory access request
  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } clrx_mem_req_type;
  // watchdog state
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] post;
  } clrx_wdt_type;
endpackage

// >>> verilog/clrx_datamem.sv
// flip-flop data memory of 512 bytes with one port
`timescale 1ns/100ps
`include "clrx_cfg.svh"
module clrx_datamem
  import clrx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access port
  input clrx_mem_req_type req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [512]; // storage
  logic [7:0] rdata_q; // registered read data

  // per-entry storage, cleared at reset
  genvar g;
  generate
    for (g = 0; g < 512; g++)
    begin : g_ent
      logic [7:0] ent_d;
      always_comb
      begin
        ent_d = mem_q[g];
        if (req_i.we && (req_i.addr == 9'(g)))
        begin
          ent_d = req_i.wdata;
        end
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          mem_q[g] <= `CLRX_ZERO8;
        else
          mem_q[g] <= ent_d;
      end
    end
  endgenerate

  // registered read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= `CLRX_ZERO8;
    else
      rdata_q <= mem_q[req_i.addr];
  end

  assign rdata_o = rdata_q;
endmodule

// >>> verilog/clrx_exec.sv
// execute logic for the file-register clear and watchdog clear instructions
//
// Summary of operation
// - register clear writes zero, sets zero flag
// - access bit zero selects access bank
// - access bit one uses bank select register
// - extended set, a=0, f<=95: indexed offset
// - watchdog clear zeroes counter and postscaler
// - watchdog clear sets timeout and powerdown flags
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`include "clrx_cfg.svh"
module clrx_exec
  import clrx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // watchdog view
  output logic [15:0] wdt_count_o,
  output logic [7:0] wdt_post_o,
  // busy while an instruction executes
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  clrx_phase_type phase_q, phase_d; // quarter phase
  clrx_kind_type kind_q, kind_d; // instruction under execution
  logic [15:0] instr_q, instr_d; // instruction word
  logic [7:0] status_q, status_d; // status register
  logic [3:0] bank_select_register_q, bank_select_register_d; // bank select
  logic [7:0] index_base_q, index_base_d; // index base for literal offset mode
  logic ext_set_q, ext_set_d; // extended instruction set enable
  logic [8:0] eaddr_q, eaddr_d; // resolved target address
  clrx_wdt_type wdt_q, wdt_d; // watchdog counter and postscaler
  logic ack_q, ack_d; // bus acknowledge
  logic [31:0] dat_q, dat_d; // bus read data
  logic [7:0] rd_data_q, rd_data_d; // target value read in Q2
  clrx_mem_req_type mreq; // data memory request
  logic [7:0] mem_rdata; // data memory read data
  logic bus_req; // valid bus cycle not yet acknowledged
  logic bus_wr; // bus write strobe
  logic [7:0] hw_set; // status bits set by execution in this cycle

  assign bus_req = cyc_i && stb_i && !ack_q;
  assign bus_wr = bus_req && we_i && sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // data memory
  clrx_datamem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(mreq),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address resolution for the register clear operand
  function automatic logic [8:0] resolve(input logic [15:0] ins, input logic xe,
                                          input logic [3:0] bank, input logic [7:0] base);
    logic [7:0] f;
    logic a;
    f = ins[7:0];
    a = ins[8];
    if (a)
      resolve = {bank[0], f};
    else if (xe && (f <= `CLRX_IDX_MAX))
      resolve = {1'b0, 8'(base + f)};
    else if (f < `CLRX_ACC_SPLIT)
      resolve = {1'b0, f};
    else
      resolve = {`CLRX_ACC_HIBANK == 4'hF, f};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    phase_d = phase_q;
    kind_d = kind_q;
    instr_d = instr_q;
    status_d = status_q;
    bank_select_register_d = bank_select_register_q;
    index_base_d = index_base_q;
    ext_set_d = ext_set_q;
    eaddr_d = eaddr_q;
    rd_data_d = rd_data_q;
    wdt_d = wdt_q;
    ack_d = bus_req;
    dat_d = dat_q;
    mreq = '{we: 1'b0, addr: eaddr_q, wdata: `CLRX_ZERO8};
    hw_set = `CLRX_ZERO8;
    // watchdog counts up, postscaler ticks on counter wrap
    wdt_d.count = wdt_q.count + 16'h0001;
    if (wdt_q.count == `CLRX_WDT_MAX)
    begin
      wdt_d.post = wdt_q.post + 8'h01;
    end
    // instruction sequencing over four quarter phases
    case (phase_q)
      CLRX_Q1:
      begin
        if (kind_q != CLRX_NONE)
        begin
          eaddr_d = resolve(instr_q, ext_set_q, bank_select_register_q, index_base_q);
          // present the new target now so its value stands in Q2
          mreq.addr = eaddr_d;
          phase_d = CLRX_Q2;
        end
      end
      CLRX_Q2:
      begin
        rd_data_d = mem_rdata;
        phase_d = CLRX_Q3;
      end
      CLRX_Q3:
      begin
        // process data: only the watchdog clear acts here; the register clear writes in Q4
        if (kind_q == CLRX_WDOG_CLR)
        begin
          wdt_d.count = 16'h0000;
          wdt_d.post = 8'h00;
          hw_set[`CLRX_ST_TMOUT] = 1'b1;
          hw_set[`CLRX_ST_PWRDN] = 1'b1;
        end
        phase_d = CLRX_Q4;
      end
      CLRX_Q4:
      begin
        if (kind_q == CLRX_FILE_CLR)
        begin
          mreq = '{we: 1'b1, addr: eaddr_q, wdata: `CLRX_ZERO8};
          hw_set[`CLRX_ST_Z] = 1'b1;
        end
        kind_d = CLRX_NONE;
        phase_d = CLRX_Q1;
      end
      default:
      begin
        phase_d = CLRX_Q1;
      end
    endcase
    // execution sets win over a software write in the same cycle
    status_d = status_q | hw_set;
    // register bus: reads return state, writes load control and issue instructions
    if (bus_req && !we_i)
    begin
      case (adr_i)
        `CLRX_ADR_CTRL: dat_d = {16'h0, index_base_q, bank_select_register_q, 3'h0, ext_set_q};
        `CLRX_ADR_INSTR: dat_d = {15'h0, kind_q != CLRX_NONE, instr_q};
        `CLRX_ADR_STATUS: dat_d = {24'h0, status_q};
        `CLRX_ADR_ADDR: dat_d = {23'h0, eaddr_q};
        `CLRX_ADR_WDT: dat_d = {8'h0, wdt_q.post, wdt_q.count};
        // operand value fetched in Q2 of the last instruction, register clear or watchdog clear
        `CLRX_ADR_MEM: dat_d = {24'h0, rd_data_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    if (bus_wr)
    begin
      case (adr_i)
        `CLRX_ADR_CTRL:
        begin
          ext_set_d = dat_i[`CLRX_CTRL_EXT];
          bank_select_register_d = dat_i[7:4];
          index_base_d = sel_i[1] ? dat_i[15:8] : index_base_q;
        end
        `CLRX_ADR_INSTR:
        begin
          // a new instruction is accepted only when idle
          if (kind_q == CLRX_NONE && sel_i[1])
          begin
            instr_d = dat_i[15:0];
            if (dat_i[15:0] == `CLRX_OP_CLRWD)
              kind_d = CLRX_WDOG_CLR;
            else if (dat_i[15:9] == `CLRX_OP_REGCLR_HI)
              kind_d = CLRX_FILE_CLR;
            else
              kind_d = CLRX_NONE;
          end
        end
        // a flag set by execution in this cycle survives the write
        `CLRX_ADR_STATUS: status_d = dat_i[7:0] | hw_set;
        default:
        begin
          kind_d = kind_d;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= CLRX_Q1;
      kind_q <= CLRX_NONE;
      instr_q <= 16'h0000;
      status_q <= `CLRX_STATUS_RST;
      bank_select_register_q <= 4'h0;
      index_base_q <= `CLRX_ZERO8;
      ext_set_q <= 1'b0;
      eaddr_q <= 9'h000;
      rd_data_q <= `CLRX_ZERO8;
      wdt_q <= '0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      phase_q <= phase_d;
      kind_q <= kind_d;
      instr_q <= instr_d;
      status_q <= status_d;
      bank_select_register_q <= bank_select_register_d;
      index_base_q <= index_base_d;
      ext_set_q <= ext_set_d;
      eaddr_q <= eaddr_d;
      rd_data_q <= rd_data_d;
      wdt_q <= wdt_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign wdt_count_o = wdt_q.count;
  assign wdt_post_o = wdt_q.post;
  assign busy_o = kind_q != CLRX_NONE;
endmodule

// >>> test/clrx_exec_asserts.sv
// concurrent checks on the ports of the clear-instruction execute block
`timescale 1ns/100ps
module clrx_exec_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // watchdog view and execute state
  input wire logic [15:0] wdt_count_o,
  input wire logic [7:0] wdt_post_o,
  input wire logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // all checks sit in the one clock domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a taken request is answered on the next edge
  a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  // acknowledge is a single-cycle pulse
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held too long");
  // no answer without a request
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("acknowledge without request");
  // execution starts with the instruction write answer
  a_busy_starts_ack: assert property ($rose(busy_o) |-> ack_o)
    else $error("execution started without bus write");
  // one instruction cycle spans several clocks but ends soon
  a_busy_bounded: assert property ($rose(busy_o) |=> busy_o ##[1:4] !busy_o)
    else $error("instruction cycle length wrong");
  // the counter steps by one or is cleared
  a_wdt_steps: assert property (1'b1 |=>
    (wdt_count_o == $past(wdt_count_o) + 16'h0001) || (wdt_count_o == 16'h0000))
    else $error("watchdog counter jumped");
  // a clear outside wrap and reset comes from an executing instruction, postscaler too
  a_wdt_clear_all: assert property (!$past(rst_i) && (wdt_count_o == 16'h0000)
    && ($past(wdt_count_o) > 16'h0001) && ($past(wdt_count_o) != 16'hFFFF)
    |-> $past(busy_o) && (wdt_post_o == 8'h00))
    else $error("watchdog cleared wrongly");
endmodule
bind clrx_exec clrx_exec_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .wdt_count_o(wdt_count_o), .wdt_post_o(wdt_post_o),
  .busy_o(busy_o));

// >>> test/tb_clrx_exec.sv
// self-checking bench for the clear-instruction execute block
`timescale 1ns/100ps
`include "clrx_cfg.svh"
module tb_clrx_exec;
  // design inputs and outputs
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o;
  logic busy_o;
  logic [15:0] wdt_count_o;
  logic [7:0] wdt_post_o;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // control word, opcode, resolved target address
  logic [40:0] rows [6] = '{{16'h0000, 16'h6A10, 9'h010}, {16'h0000, 16'h6A80, 9'h180},
    {16'h0010, 16'h6B22, 9'h122}, {16'h0000, 16'h6B22, 9'h022},
    {16'h2001, 16'h6A5F, 9'h07F}, {16'h2001, 16'h6A60, 9'h160}};
  ////////////////////////////////////////////////////////////////////////////////
  // clock and device under test
  always #5 clk_i = ~clk_i;
  clrx_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wdt_count_o(wdt_count_o), .wdt_post_o(wdt_post_o), .busy_o(busy_o));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and run end
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      conclude;
    end
  end
  // word comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until acknowledged
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // clear flags then issue an opcode
  task run(input logic [15:0] op);
    wb(1'b1, `CLRX_ADR_STATUS, 32'h0, rd);
    wb(1'b1, `CLRX_ADR_INSTR, {16'h0, op}, rd);
  endtask
  // wait for the instruction to finish
  task settle;
    for (int n = 0; n < 20 && busy_o !== 1'b0; n++) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
    chk(rd, {24'h0, `CLRX_STATUS_RST});
    $display("reset test done");
    foreach (rows[i])
    begin
      wb(1'b1, `CLRX_ADR_CTRL, {16'h0, rows[i][40:25]}, rd);
      run(rows[i][24:9]);
      settle;
      wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
      chk(rd, 32'h4);
      wb(1'b0, `CLRX_ADR_ADDR, 32'h0, rd);
      chk(rd, {23'h0, rows[i][8:0]});
    end
    $display("addressing table done");
    // watchdog clear sets both flags, leaves zero flag
    run(16'h0004);
    settle;
    wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
    chk(rd, 32'h18);
    wb(1'b0, `CLRX_ADR_WDT, 32'h0, rd);
    chk(rd & 32'hFFFFFFF0, 32'h0);
    chk({8'h0, wdt_post_o, wdt_count_o} & 32'hFFFFFFF0, 32'h0);
    $display("watchdog test done");
    // a status write landing on the flag-setting edge loses to the set
    run(16'h0004);
    wb(1'b1, `CLRX_ADR_STATUS, 32'h4, rd);
    settle;
    wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
    chk(rd, 32'h1C);
    $display("set priority test done");
    // a second opcode while busy is dropped
    run(16'h6A10);
    chk({31'h0, busy_o}, 32'h1);
    wb(1'b1, `CLRX_ADR_INSTR, 32'h4, rd);
    settle;
    wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
    chk(rd, 32'h4);
    $display("busy test done");
    // reset while idle after the last instruction restores flags
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CLRX_ADR_STATUS, 32'h0, rd);
    chk(rd, {24'h0, `CLRX_STATUS_RST});
    $display("second reset test done");
    conclude;
  end
endmodule
